/* logic/rcr_pkg.sv */
package rcr_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] RCR_OFS_CAP_PRI = 8'h20;
    localparam logic [7:0] RCR_OFS_CAP_SEC = 8'h21;
    localparam logic [7:0] RCR_RST_CAP = 8'h00;
    localparam logic [7:0] RCR_RD_UNMAPPED = 8'h00;
    localparam int RCR_PORTS = 2;

    // ----------------------------------------
    // Field positions in the primary register
    // ----------------------------------------
    localparam int RCR_BIT_HOLD = 7;
    localparam int RCR_BIT_MODE_LO = 6;
    localparam int RCR_BIT_FREQ = 5;
    localparam int RCR_BIT_TWO_LINK = 4;
    localparam int RCR_BIT_EQ = 3;
    localparam int RCR_BIT_ROLE = 2;
    // Field positions in the secondary register
    localparam int RCR_BIT_MODE_HI_MSB = 1;
    localparam int RCR_BIT_MODE_HI_LSB = 0;

    // ----------------------------------------
    // Mode codes of the fast control channel
    // ----------------------------------------
    localparam logic [2:0] RCR_MODE_NORMAL = 3'h0;
    localparam logic [2:0] RCR_MODE_PIN1 = 3'h1;
    localparam logic [2:0] RCR_MODE_PIN2 = 3'h2;
    localparam logic [2:0] RCR_MODE_PIN4 = 3'h3;
    localparam logic [2:0] RCR_MODE_SER_FWD = 3'h6;
    localparam logic [2:0] RCR_MODE_SER_REV = 3'h7;

    typedef enum logic [2:0] {
        RCR_KIND_NORMAL,
        RCR_KIND_PIN1,
        RCR_KIND_PIN2,
        RCR_KIND_PIN4,
        RCR_KIND_SER_FWD,
        RCR_KIND_SER_REV,
        RCR_KIND_RESERVED
    } rcr_kind_t;

    // Capabilities reported by the far receiver
    typedef struct packed {
        logic [2:0] fast_ctrl_channel_select;
        logic freq_training_request;
        logic equalizer_training_request;
        logic two_link_support;
        logic channel_role;
    } rcr_cap_t;

    // Register access request
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcr_req_t;

    localparam rcr_cap_t RCR_CAP_RST = '0;

endpackage : rcr_pkg

/* logic/rcr_remote_cap.sv */
`timescale 1ns/100ps

// Function
// - Hold bit blocks automatic capability loading.
// - Held values are software-written effective capabilities.
// - Mode low bit lives here.
// - Unheld fields load from report after lock.
// - Port select redirects access to Port1 copy.
// - Frequency training request flag, read/write.
// - Equalizer training request flag, read/write.
// - Flag shows remote two-link support.
// - Role flag: 0 primary, 1 secondary.
// - Hold and mode low bit reset zero.
// - Mode upper bits in second register.
// - Decode three-bit mode into channel kinds.
module rcr_remote_cap
    import rcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Register access
    input wire rcr_req_t req,
    input wire logic second_port_view,
    output logic [7:0] rdata,
    output logic rvalid,
    // Back channel reports, per port
    input wire logic [RCR_PORTS-1:0] rx_lock,
    input wire logic [RCR_PORTS-1:0] report_valid,
    input wire rcr_cap_t [RCR_PORTS-1:0] report_cap,
    // Effective capabilities, per port
    output rcr_cap_t [RCR_PORTS-1:0] eff_cap,
    output logic [RCR_PORTS-1:0] cap_held,
    output rcr_kind_t [RCR_PORTS-1:0] mode_kind
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire logic hit_pri = req.addr == RCR_OFS_CAP_PRI;
    wire logic hit_sec = req.addr == RCR_OFS_CAP_SEC;
    wire logic sel = second_port_view;

    // ----------------------------------------
    // Lock synchronisers
    // ----------------------------------------
    logic [RCR_PORTS-1:0] lock_meta_r;
    logic [RCR_PORTS-1:0] lock_sync_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            lock_meta_r <= '0;
            lock_sync_r <= '0;
        end else if (ce) begin
            lock_meta_r <= rx_lock;
            lock_sync_r <= lock_meta_r;
        end
    end

    // ----------------------------------------
    // Per-port capability storage
    // ----------------------------------------
    rcr_cap_t [RCR_PORTS-1:0] cap_r;
    logic [RCR_PORTS-1:0] hold_r;
    logic [7:0] rd_pri [RCR_PORTS];
    logic [7:0] rd_sec [RCR_PORTS];

    genvar p;
    generate
        for (p = 0; p < RCR_PORTS; p++) begin : g_port
            wire logic this_port = (sel == 1'(p));
            wire logic wr_pri = req.wr_en && hit_pri && this_port;
            wire logic wr_sec = req.wr_en && hit_sec && this_port;
            wire logic auto_ld = report_valid[p] && lock_sync_r[p] && !hold_r[p];
            rcr_cap_t cap_nxt;
            logic hold_nxt;

            // ----------------------------------------
            // Next value of this port
            // ----------------------------------------
            always_comb begin
                cap_nxt = cap_r[p];
                hold_nxt = hold_r[p];
                if (auto_ld) begin
                    cap_nxt = report_cap[p];
                end
                // Software write wins over a same-cycle report
                if (wr_pri) begin
                    hold_nxt = req.wdata[RCR_BIT_HOLD];
                    cap_nxt.fast_ctrl_channel_select[0] = req.wdata[RCR_BIT_MODE_LO];
                    cap_nxt.freq_training_request = req.wdata[RCR_BIT_FREQ];
                    cap_nxt.two_link_support = req.wdata[RCR_BIT_TWO_LINK];
                    cap_nxt.equalizer_training_request = req.wdata[RCR_BIT_EQ];
                    cap_nxt.channel_role = req.wdata[RCR_BIT_ROLE];
                end
                if (wr_sec) begin
                    cap_nxt.fast_ctrl_channel_select[2:1] =
                        req.wdata[RCR_BIT_MODE_HI_MSB:RCR_BIT_MODE_HI_LSB];
                end
            end

            // ----------------------------------------
            // Storage of this port
            // ----------------------------------------
            always_ff @(posedge clk) begin
                if (rst) begin
                    cap_r[p] <= RCR_CAP_RST;
                    hold_r[p] <= RCR_RST_CAP[RCR_BIT_HOLD];
                end else if (ce) begin
                    cap_r[p] <= cap_nxt;
                    hold_r[p] <= hold_nxt;
                end
            end

            // ----------------------------------------
            // Read images of both registers
            // ----------------------------------------
            always_comb begin
                rd_pri[p] = RCR_RST_CAP;
                rd_pri[p][RCR_BIT_HOLD] = hold_r[p];
                rd_pri[p][RCR_BIT_MODE_LO] = cap_r[p].fast_ctrl_channel_select[0];
                rd_pri[p][RCR_BIT_FREQ] = cap_r[p].freq_training_request;
                rd_pri[p][RCR_BIT_TWO_LINK] = cap_r[p].two_link_support;
                rd_pri[p][RCR_BIT_EQ] = cap_r[p].equalizer_training_request;
                rd_pri[p][RCR_BIT_ROLE] = cap_r[p].channel_role;
                rd_sec[p] = RCR_RST_CAP;
                rd_sec[p][RCR_BIT_MODE_HI_MSB:RCR_BIT_MODE_HI_LSB] =
                    cap_r[p].fast_ctrl_channel_select[2:1];
            end

            // ----------------------------------------
            // Effective outputs of this port
            // ----------------------------------------
            wire rcr_kind_t kind_nxt = rcr_decode(cap_r[p].fast_ctrl_channel_select);

            always_ff @(posedge clk) begin
                if (rst) begin
                    eff_cap[p] <= RCR_CAP_RST;
                    cap_held[p] <= RCR_RST_CAP[RCR_BIT_HOLD];
                    mode_kind[p] <= RCR_KIND_NORMAL;
                end else if (ce) begin
                    eff_cap[p] <= cap_r[p];
                    cap_held[p] <= hold_r[p];
                    mode_kind[p] <= kind_nxt;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire logic [7:0] rd_mux = hit_pri ? rd_pri[sel] :
                              hit_sec ? rd_sec[sel] : RCR_RD_UNMAPPED;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= RCR_RD_UNMAPPED;
            rvalid <= 1'b0;
        end else if (ce) begin
            rvalid <= req.rd_en;
            if (req.rd_en) begin
                rdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    function automatic rcr_kind_t rcr_decode(input logic [2:0] code);
        case (code)
            RCR_MODE_NORMAL: rcr_decode = RCR_KIND_NORMAL;
            RCR_MODE_PIN1: rcr_decode = RCR_KIND_PIN1;
            RCR_MODE_PIN2: rcr_decode = RCR_KIND_PIN2;
            RCR_MODE_PIN4: rcr_decode = RCR_KIND_PIN4;
            RCR_MODE_SER_FWD: rcr_decode = RCR_KIND_SER_FWD;
            RCR_MODE_SER_REV: rcr_decode = RCR_KIND_SER_REV;
            default: rcr_decode = RCR_KIND_RESERVED;
        endcase
    endfunction : rcr_decode

endmodule : rcr_remote_cap

/* sim/rcr_bc_model.sv */
`timescale 1ns/100ps
module rcr_bc_model
    import rcr_pkg::*;
(
    // Far receiver lines
    input wire logic clk,
    output logic [RCR_PORTS-1:0] rx_lock, report_valid,
    output rcr_cap_t [RCR_PORTS-1:0] report_cap
);
    initial begin
        rx_lock = '0;
        report_valid = '0;
        report_cap = '1;
    end
    // Lock, settle d cycles, report once, then scramble
    task send(input int p, input rcr_cap_t v, input int d);
        rx_lock[p] = 1'b1;
        repeat (d) @(negedge clk);
        report_cap[p] = v;
        report_valid[p] = 1'b1;
        @(negedge clk);
        report_valid[p] = 1'b0;
        report_cap[p] = ~v;
    endtask : send
endmodule : rcr_bc_model

/* sim/rcr_remote_cap_checker.sv */
`timescale 1ns/100ps
module rcr_remote_cap_checker
    import rcr_pkg::*;
(
    // Watched ports
    input wire logic clk, rst, ce, second_port_view, rvalid,
    input wire rcr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic [RCR_PORTS-1:0] rx_lock, report_valid, cap_held,
    input wire rcr_cap_t [RCR_PORTS-1:0] report_cap, eff_cap,
    input wire rcr_kind_t [RCR_PORTS-1:0] mode_kind
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire rcr_cap_t c = eff_cap[0];
    wire [2:0] m = c.fast_ctrl_channel_select;
    wire idle = ce && !req.wr_en;
    wire w0 = ce && req.wr_en && !second_port_view;
    sequence s_held;
        (idle && cap_held[0]) [*2];
    endsequence
    sequence s_free;
        (idle && rx_lock[0]) [*3] ##1 (idle && rx_lock[0] && report_valid[0] && !cap_held[0]);
    endsequence
    a_read_valid: assert property (ce && req.rd_en |=> rvalid) else $error("no read answer");
    a_upper_zero: assert property (ce && req.rd_en && req.addr == 8'h21 |=> rdata[7:2] == 6'h00)
        else $error("reserved bits set");
    a_hold_keeps: assert property (s_held |=> $stable(c)) else $error("held value moved");
    a_load_free: assert property (s_free |-> ##2 c == $past(report_cap[0], 2)) else $error("no load");
    a_port1_write: assert property (ce && req.wr_en && second_port_view && req.addr == 8'h20 |->
        ##2 cap_held[1] == $past(req.wdata[7], 2) && $stable(cap_held[0])) else $error("port one write");
    a_fields_write: assert property (w0 && req.addr == 8'h20 |-> ##2
        {m[0], c.freq_training_request, c.two_link_support, c.equalizer_training_request, c.channel_role}
        == $past(req.wdata[6:2], 2)) else $error("field write");
    a_mode_high: assert property (w0 && req.addr == 8'h21 |-> ##2 m[2:1] == $past(req.wdata[1:0], 2))
        else $error("mode high bits");
    a_mode_decode: assert property (mode_kind[0] == (m < 3'h4 ? rcr_kind_t'(m) :
        m > 3'h5 ? rcr_kind_t'(m - 3'h2) : RCR_KIND_RESERVED)) else $error("mode decode");
endmodule : rcr_remote_cap_checker
bind rcr_remote_cap rcr_remote_cap_checker chk_u (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .second_port_view(second_port_view),
    .rvalid(rvalid),
    .req(req),
    .rdata(rdata),
    .rx_lock(rx_lock),
    .report_valid(report_valid),
    .cap_held(cap_held),
    .report_cap(report_cap),
    .eff_cap(eff_cap),
    .mode_kind(mode_kind)
);

/* sim/tb.sv */
`timescale 1ns/100ps
module tb
    import rcr_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, second_port_view = 1'b0, rvalid;
    rcr_req_t req = '0;
    logic [7:0] rdata;
    logic [RCR_PORTS-1:0] rx_lock, report_valid, cap_held;
    rcr_cap_t [RCR_PORTS-1:0] report_cap, eff_cap;
    rcr_kind_t [RCR_PORTS-1:0] mode_kind;
    int bad_count, check_count;
    rcr_remote_cap dut_u (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .req(req),
        .second_port_view(second_port_view),
        .rdata(rdata),
        .rvalid(rvalid),
        .rx_lock(rx_lock),
        .report_valid(report_valid),
        .report_cap(report_cap),
        .eff_cap(eff_cap),
        .cap_held(cap_held),
        .mode_kind(mode_kind)
    );
    rcr_bc_model bc_u (
        .clk(clk),
        .rx_lock(rx_lock),
        .report_valid(report_valid),
        .report_cap(report_cap)
    );
    initial forever #2.5 clk = ~clk;
    initial begin
        repeat (1000) @(posedge clk);
        bad_count++;
        stop_test();
    end
    task chk(input string n, input logic [8:0] e, g);
        check_count++;
        bad_count += (g !== e);
        if (g !== e) $display("wrong value %s expected %h seen %h", n, e, g);
    endtask : chk
    // One access; a read checks answer and data
    task acc(input logic w, input logic v, input logic [7:0] a, input logic [7:0] d);
        req = '{w, !w, a, w ? d : 8'h00};
        second_port_view = v;
        @(negedge clk);
        req = '0;
        if (!w) chk("read", {1'b1, d}, {rvalid, rdata});
        @(negedge clk);
    endtask : acc
    task stop_test();
        $display("checks %0d bad %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task t_load();
        acc(1'b0, 1'b0, 8'h20, 8'h00);
        bc_u.send(0, 7'h55, 4);
        bc_u.send(1, 7'h3A, 6);
        acc(1'b0, 1'b0, 8'h20, 8'h4C);
        acc(1'b0, 1'b1, 8'h20, 8'h70);
        acc(1'b0, 1'b1, 8'h21, 8'h01);
        chk("cap0", {2'b00, 7'h55}, {2'b00, eff_cap[0]});
        chk("cap1", {2'b00, 7'h3A}, {2'b00, eff_cap[1]});
        chk("kind0", {6'h00, RCR_KIND_RESERVED}, {6'h00, mode_kind[0]});
        chk("kind1", {6'h00, RCR_KIND_PIN4}, {6'h00, mode_kind[1]});
        $display("load done");
    endtask : t_load
    task t_hold();
        acc(1'b1, 1'b0, 8'h20, 8'hFC);
        acc(1'b1, 1'b0, 8'h21, 8'h02);
        bc_u.send(0, 7'h00, 4);
        acc(1'b0, 1'b0, 8'h20, 8'hFC);
        acc(1'b0, 1'b0, 8'h21, 8'h02);
        acc(1'b1, 1'b1, 8'h20, 8'hA8);
        acc(1'b0, 1'b1, 8'h20, 8'hA8);
        chk("held", 9'h003, {7'h00, cap_held});
        acc(1'b0, 1'b0, 8'h33, RCR_RD_UNMAPPED);
        $display("hold done");
    endtask : t_hold
    task t_modes();
        for (int m = 0; m < 8; m++) begin
            acc(1'b1, 1'b0, 8'h20, {1'b1, m[0], 6'h00});
            acc(1'b1, 1'b0, 8'h21, {6'h00, m[2:1]});
        end
        chk("kind", {6'h00, RCR_KIND_SER_REV}, {6'h00, mode_kind[0]});
        $display("mode done");
    endtask : t_modes
    // Write ignored while frozen, then a second reset
    task t_freeze();
        ce = 1'b0;
        acc(1'b1, 1'b0, 8'h20, 8'h00);
        ce = 1'b1;
        acc(1'b0, 1'b0, 8'h20, 8'hC0);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        acc(1'b0, 1'b0, 8'h20, RCR_RST_CAP);
        acc(1'b0, 1'b1, 8'h21, RCR_RST_CAP);
        chk("held", 9'h000, {7'h00, cap_held});
        chk("kind", {6'h00, RCR_KIND_NORMAL}, {6'h00, mode_kind[0]});
        $display("freeze done");
    endtask : t_freeze
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_load();
        t_hold();
        t_modes();
        t_freeze();
        stop_test();
    end
endmodule : tb
